// ==== hw/amp_pulse_gen.v ====
// Purpose: amplitude modulation gate generator with AHB-Lite registers
// Assumes: knob inputs are slow pins; bus on hclk; one slave on the bus
// Notes:   rate and width knobs are read-only to software
`timescale 1ns/1ns
`default_nettype none
`include "amp_regs.vh"
module amp_pulse_gen #(
  parameter [19:0] PRESET_PERIOD_CYC = `AMP_PRESET_PERIOD_NS / `AMP_CLK_PERIOD_NS
) (
  // clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output wire [31:0] hrdata,
  // local front-panel controls
  input  wire        pulse_rate_control,
  input  wire [9:0]  rate_setting,
  input  wire        rate_times_five,
  input  wire [6:0]  width_setting,
  // sync port, two-way
  input  wire        am_sync_port_in,
  output wire        am_sync_port_out,
  output wire        am_sync_port_oe,
  // rf modulator drive
  output wire        rf_gate_on,
  output wire        rf_atten_30db
);
  localparam [19:0] RATE_UNIT_CYC = `AMP_RATE_UNIT_NS / `AMP_CLK_PERIOD_NS;
  localparam [19:0] RATE_X5_CYC   = RATE_UNIT_CYC / `AMP_X5_FACTOR;
  localparam [9:0]  CAL_WIDTH_CYC =
    (`AMP_CAL_WIDTH_NS + `AMP_CLK_PERIOD_NS - 1) / `AMP_CLK_PERIOD_NS;
  localparam [9:0]  WIDTH_UNIT_CYC = `AMP_WIDTH_UNIT_NS / `AMP_CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------
  reg        wr_pend_q;
  reg [31:0] wr_addr_q;
  reg [2:0]  mode_q;
  reg [2:0]  mode_prev_q;
  reg        clr_req_q;
  reg [31:0] hrdata_q;
  wire       bus_acc;
  wire [2:0] wr_mode;
  wire       wr_mode_ok;
  reg [31:0] rd_mux;

  // zero wait states: every transfer finishes in its first data cycle
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;
  assign bus_acc   = hsel & htrans[1] & hready;
  assign wr_mode   = hwdata[`AMP_CTRL_MODE_MSB:`AMP_CTRL_MODE_LSB];
  // codes above the last mode are not stored, so the mode stays decodable
  assign wr_mode_ok = (wr_mode <= `AMP_MODE_EXT_FALL);

  // address phase capture for writes
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 32'h0000_0000;
    end else begin
      wr_pend_q <= bus_acc & hwrite;
      if (bus_acc) begin
        wr_addr_q <= haddr;
      end
    end
  end

  // control register; mode and count clear are written here, knobs are read-only
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_q    <= `AMP_CTRL_RESET;
      clr_req_q <= 1'b0;
    end else begin
      clr_req_q <= 1'b0;
      if (wr_pend_q && wr_addr_q == `AMP_ADDR_CTRL) begin
        if (wr_mode_ok) begin
          mode_q <= wr_mode; // RL17
        end
        clr_req_q <= hwdata[`AMP_CTRL_CLR_BIT];
      end
    end
  end

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  reg        sync_m_q;
  reg        sync_s_q;
  reg        sync_d_q;
  reg        prc_m_q;
  reg        prc_s_q;
  reg        x5_m_q;
  reg        x5_s_q;
  reg [9:0]  rate_m_q;
  reg [9:0]  rate_s_q;
  reg [6:0]  wid_m_q;
  reg [6:0]  wid_s_q;

  // knob buses are synchronised bitwise; a value caught mid-turn is
  // harmless because it is only taken at a period start or an external trigger
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_m_q <= 1'b0;
      sync_s_q <= 1'b0;
      sync_d_q <= 1'b0;
      prc_m_q  <= 1'b1;
      prc_s_q  <= 1'b1;
      x5_m_q   <= 1'b0;
      x5_s_q   <= 1'b0;
      rate_m_q <= 10'h000;
      rate_s_q <= 10'h000;
      wid_m_q  <= 7'h00;
      wid_s_q  <= 7'h00;
    end else begin
      sync_m_q <= am_sync_port_in; // RL19
      sync_s_q <= sync_m_q; // RL19
      sync_d_q <= sync_s_q;
      prc_m_q  <= pulse_rate_control;
      prc_s_q  <= prc_m_q;
      x5_m_q   <= rate_times_five;
      x5_s_q   <= x5_m_q;
      rate_m_q <= rate_setting;
      rate_s_q <= rate_m_q;
      wid_m_q  <= width_setting;
      wid_s_q  <= wid_m_q;
    end
  end

  // ---------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------
  wire is_off  = (mode_q == `AMP_MODE_OFF);
  wire is_cal  = (mode_q == `AMP_MODE_CAL);
  wire is_var  = (mode_q == `AMP_MODE_VAR);
  wire is_sq   = (mode_q == `AMP_MODE_SQUARE);
  wire is_rise = (mode_q == `AMP_MODE_EXT_RISE);
  wire is_fall = (mode_q == `AMP_MODE_EXT_FALL);
  wire is_int  = is_cal | is_var | is_sq;
  wire is_ext  = is_rise | is_fall;

  // ---------------------------------------------------------------
  // rate and width selection from the local knobs
  // ---------------------------------------------------------------
  reg  [9:0]  rate_units;
  reg  [6:0]  wid_units;
  wire [19:0] var_period;
  wire [19:0] sel_period;
  wire [9:0]  var_width;
  wire [9:0]  sel_width;

  // clamp knob readings into the documented spans
  always @* begin
    rate_units = rate_s_q;
    if (rate_s_q < `AMP_RATE_MIN) begin
      rate_units = `AMP_RATE_MIN; // RL15
    end else if (rate_s_q > `AMP_RATE_MAX) begin
      rate_units = `AMP_RATE_MAX; // RL15
    end
    wid_units = wid_s_q;
    if (wid_s_q < `AMP_WIDTH_MIN) begin
      wid_units = `AMP_WIDTH_MIN; // RL4
    end else if (wid_s_q > `AMP_WIDTH_MAX) begin
      wid_units = `AMP_WIDTH_MAX; // RL4
    end
  end

  // times five shortens the period by the factor, span 500 Hz to 50 kHz
  assign var_period = {10'h000, rate_units} *
                      (x5_s_q ? RATE_X5_CYC : RATE_UNIT_CYC); // RL16
  // calibrated mode or the preset detent ignore the variable setting
  assign sel_period = (is_cal | prc_s_q) ? PRESET_PERIOD_CYC // RL1 RL14
                                         : var_period; // RL6 RL8
  assign var_width  = {3'h0, wid_units} * WIDTH_UNIT_CYC; // RL4
  assign sel_width  = is_cal ? CAL_WIDTH_CYC : var_width; // RL2

  // ---------------------------------------------------------------
  // period counter
  // ---------------------------------------------------------------
  reg  [19:0] per_cnt_q;
  reg  [19:0] per_len_q;
  reg  [19:0] half_q;
  reg         first_q;
  wire        wrap;
  wire        period_start;
  wire        sq_level;

  assign wrap         = (per_cnt_q >= per_len_q - 20'h0_0001);
  assign period_start = is_int & (first_q | wrap);
  // first half of each period is the high half of the square
  assign sq_level     = is_sq & ~first_q & (per_cnt_q < half_q); // RL7

  // a mode change restarts the period so the first pulse is whole
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_prev_q <= `AMP_CTRL_RESET;
      first_q     <= 1'b1;
      per_cnt_q   <= 20'h0_0000;
      per_len_q   <= 20'h0_0001;
      half_q      <= 20'h0_0000;
    end else begin
      mode_prev_q <= mode_q;
      if (mode_prev_q != mode_q || !is_int) begin
        first_q   <= 1'b1;
        per_cnt_q <= 20'h0_0000;
      end else if (period_start) begin
        first_q   <= 1'b0;
        per_cnt_q <= 20'h0_0000; // RL18
        per_len_q <= sel_period; // RL18
        half_q    <= {1'b0, sel_period[19:1]}; // RL7
      end else begin
        per_cnt_q <= per_cnt_q + 20'h0_0001;
      end
    end
  end

  // ---------------------------------------------------------------
  // pulse timer, shared by internal and triggered pulses
  // ---------------------------------------------------------------
  wire ext_rise = sync_s_q & ~sync_d_q;
  wire ext_fall = ~sync_s_q & sync_d_q;
  wire ext_edge = (is_rise & ext_rise) | // RL10
                  (is_fall & ext_fall); // RL11
  wire tmr_start = (period_start & (is_cal | is_var)) | ext_edge;
  wire tmr_busy;
  wire tmr_acc;

  amp_width_timer #(
    .W (10)
  ) u_timer (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .start    (tmr_start),
    .width    (sel_width),
    .busy     (tmr_busy),
    .accepted (tmr_acc)
  );

  // ---------------------------------------------------------------
  // trigger accounting
  // ---------------------------------------------------------------
  reg [15:0] trig_cnt_q;
  reg [15:0] miss_cnt_q;
  wire       trig_miss = ext_edge & ~tmr_acc;

  // a count that lands with a clear survives as one
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trig_cnt_q <= 16'h0000;
      miss_cnt_q <= 16'h0000;
    end else begin
      if (clr_req_q) begin
        trig_cnt_q <= {15'h0000, ext_edge & tmr_acc};
        miss_cnt_q <= {15'h0000, trig_miss};
      end else begin
        if (ext_edge & tmr_acc) begin
          trig_cnt_q <= trig_cnt_q + 16'h0001;
        end
        if (trig_miss) begin
          miss_cnt_q <= miss_cnt_q + 16'h0001; // RL19
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // rf and sync drive, all from flops
  // ---------------------------------------------------------------
  reg gate_q;
  reg att_q;
  reg sync_out_q;
  reg sync_oe_q;

  // pulse modes blank fully; square drops 30 dB in its low half
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gate_q     <= 1'b1;
      att_q      <= 1'b0;
      sync_out_q <= 1'b0;
      sync_oe_q  <= 1'b0;
    end else begin
      sync_oe_q  <= is_int; // RL13
      sync_out_q <= 1'b0;
      att_q      <= 1'b0;
      if (is_off) begin
        gate_q <= 1'b1; // RL9
      end else if (is_sq) begin
        gate_q     <= sq_level; // RL7
        att_q      <= ~sq_level; // RL7
        sync_out_q <= sq_level; // RL8
      end else if (is_ext) begin
        gate_q <= tmr_busy; // RL10 RL11
      end else begin
        gate_q     <= tmr_busy; // RL5
        sync_out_q <= tmr_busy; // RL3
      end
    end
  end

  assign rf_gate_on       = gate_q;
  assign rf_atten_30db    = att_q;
  assign am_sync_port_out = sync_out_q;
  assign am_sync_port_oe  = sync_oe_q;

  // ---------------------------------------------------------------
  // read data, latched in the address phase
  // ---------------------------------------------------------------
  always @* begin
    rd_mux = 32'h0000_0000;
    case (haddr)
      `AMP_ADDR_CTRL: begin
        rd_mux[`AMP_CTRL_MODE_MSB:`AMP_CTRL_MODE_LSB] = mode_q;
      end
      `AMP_ADDR_STATUS: begin
        rd_mux[`AMP_STAT_GATE_BIT] = gate_q;
        rd_mux[`AMP_STAT_ATT_BIT]  = att_q;
        rd_mux[`AMP_STAT_OE_BIT]   = sync_oe_q;
        rd_mux[`AMP_STAT_BUSY_BIT] = tmr_busy;
        rd_mux[`AMP_STAT_SYNC_BIT] = sync_s_q;
      end
      `AMP_ADDR_TRIGCNT: begin
        rd_mux = {miss_cnt_q, trig_cnt_q};
      end
      `AMP_ADDR_KNOBS: begin
        rd_mux = {5'h00, x5_s_q, prc_s_q, wid_units, 8'h00, rate_units};
      end
      `AMP_ADDR_PERIOD: begin
        rd_mux = {12'h000, per_len_q};
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0000_0000;
    end else if (bus_acc & ~hwrite) begin
      hrdata_q <= rd_mux;
    end
  end

  // hsize is accepted as a whole word on every transfer
  wire unused_ok = &{1'b0, hsize};
endmodule // amp_pulse_gen
`default_nettype wire

// ==== hw/amp_width_timer.v ====
// Purpose: one-shot that holds busy for exactly width cycles
// Assumes: start and width come from logic on the same clock
// Notes:   a start while busy is dropped, not queued
`timescale 1ns/1ns
`default_nettype none
module amp_width_timer #(
  parameter W = 10
) (
  // clock and reset
  input  wire         hclk,
  input  wire         hresetn,
  // request
  input  wire         start,
  input  wire [W-1:0] width,
  // state
  output wire         busy,
  output wire         accepted
);
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_RUN  = 2'b10;

  reg [1:0]   state_q;
  reg [W-1:0] cnt_q;

  // a zero width is refused so a pulse never collapses to nothing
  assign accepted = start & state_q[0] & (width != {W{1'b0}}); // RL19
  assign busy     = state_q[1];

  // width counter loaded once per pulse
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ST_IDLE;
      cnt_q   <= {W{1'b0}};
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (accepted) begin
            cnt_q   <= width - {{(W-1){1'b0}}, 1'b1}; // RL18
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (cnt_q == {W{1'b0}}) begin
            state_q <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // amp_width_timer
`default_nettype wire

// ==== include/amp_regs.vh ====
// Purpose: constants for the amplitude modulation pulse generator
// Assumes: 100 MHz hclk, AHB-Lite register slave, one word per register
// Notes:   times are kept in their own unit; cycle counts derive from them
// Contract
// (RL1) Calibrated pulse repeats at a fixed 1 kHz whatever the rate knob says.
// (RL2) Calibrated pulse is a fixed 1 us wide, width knob ignored.
// (RL3) Internal pulse modes drive a TTL copy of the pulse onto the sync port.
// (RL4) Variable pulse width follows the width knob, 0.1 us to 10 us.
// (RL5) Variable pulse switches RF fully; burst lasts exactly the gate pulse.
// (RL6) Variable pulse repeats at 1 kHz unless the rate control picks another.
// (RL7) Squarewave is 50 percent duty: RF on first half, 30 dB down second.
// (RL8) Squarewave goes out on the sync port; its rate follows the rate control.
// (RL9) Modulation off holds the RF gate on continuously.
// (RL10) Rising-edge external mode starts a pulse on each sync-port low-to-high.
// (RL11) Falling-edge external mode starts a pulse on each sync-port high-to-low.
// (RL12) The outside source drives a TTL pulse signal into the sync port.
// (RL13) Sync port outputs in internal modes, inputs in external modes.
// (RL14) Rate control in preset position gives a fixed 1 kHz.
// (RL15) Rate control in variable position gives 100 Hz to 10 kHz.
// (RL16) Times-five multiplies the variable rate by five, 500 Hz to 50 kHz.
// (RL17) Rate and width come only from local controls, never from the bus.
// (RL18) Period and width come from hclk counters reloaded at each period start.
// (RL19) Trigger passes two flops before edge detect; edges ignored while busy.
`ifndef AMP_REGS_VH
`define AMP_REGS_VH

// register byte addresses
`define AMP_ADDR_CTRL      32'h0000_0000
`define AMP_ADDR_STATUS    32'h0000_0004
`define AMP_ADDR_TRIGCNT   32'h0000_0008
`define AMP_ADDR_KNOBS     32'h0000_000C
`define AMP_ADDR_PERIOD    32'h0000_0010

// control fields
`define AMP_CTRL_MODE_LSB  0
`define AMP_CTRL_MODE_MSB  2
`define AMP_CTRL_CLR_BIT   8
`define AMP_CTRL_RESET     3'h0

// mode codes
`define AMP_MODE_OFF       3'h0
`define AMP_MODE_CAL       3'h1
`define AMP_MODE_VAR       3'h2
`define AMP_MODE_SQUARE    3'h3
`define AMP_MODE_EXT_RISE  3'h4
`define AMP_MODE_EXT_FALL  3'h5

// status fields
`define AMP_STAT_GATE_BIT  0
`define AMP_STAT_ATT_BIT   1
`define AMP_STAT_OE_BIT    2
`define AMP_STAT_BUSY_BIT  3
`define AMP_STAT_SYNC_BIT  4

// timing
`define AMP_CLK_PERIOD_NS    10
`define AMP_PRESET_PERIOD_NS 1000000
`define AMP_CAL_WIDTH_NS     1000
`define AMP_WIDTH_UNIT_NS    100
`define AMP_WIDTH_MIN        7'h01
`define AMP_WIDTH_MAX        7'h64
`define AMP_RATE_UNIT_NS     10000
`define AMP_RATE_MIN         10'h00A
`define AMP_RATE_MAX         10'h3E8
`define AMP_X5_FACTOR        5

`endif

// ==== test/amp_pulse_gen_asserts.sv ====
// Purpose: concurrent checks on the modulation gate and the sync port
// Assumes: one hclk domain, asynchronous active-low reset
// Notes:   mode is not a port, so checks lean on oe and on bus write age
`timescale 1ns/1ns
`default_nettype none
module amp_pulse_gen_asserts #(
  parameter [19:0] PRESET_PERIOD_CYC = 20'h1_86a0
) (
  // clock and reset
  input wire logic       hclk,
  input wire logic       hresetn,
  // bus activity
  input wire logic       hsel,
  input wire logic [1:0] htrans,
  input wire logic       hwrite,
  input wire logic       hready,
  // sync port and rf drive
  input wire logic       am_sync_port_in,
  input wire logic       am_sync_port_out,
  input wire logic       am_sync_port_oe,
  input wire logic       rf_gate_on,
  input wire logic       rf_atten_30db
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [3:0]  wr_age_q;
  logic [3:0]  pin_age_q;
  logic [15:0] hi_cnt_q;
  logic [15:0] hi_len_q;
  logic [15:0] lo_cnt_q;
  // ages saturate so a long quiet spell never wraps into a fresh event
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_age_q  <= 4'hf;
      pin_age_q <= 4'hf;
      hi_cnt_q  <= 16'h0000;
      hi_len_q  <= 16'h0000;
      lo_cnt_q  <= 16'h0000;
    end else begin
      wr_age_q  <= (hsel && htrans[1] && hwrite && hready) ? 4'h0 :
                   (wr_age_q == 4'hf) ? wr_age_q : wr_age_q + 4'h1;
      pin_age_q <= $changed(am_sync_port_in) ? 4'h0 :
                   (pin_age_q == 4'hf) ? pin_age_q : pin_age_q + 4'h1;
      hi_cnt_q  <= rf_gate_on ? hi_cnt_q + 16'h0001 : 16'h0000;
      lo_cnt_q  <= rf_atten_30db ? lo_cnt_q + 16'h0001 : 16'h0000;
      if ($fell(rf_gate_on)) begin
        hi_len_q <= hi_cnt_q;
      end
    end
  end
  sync_copy_a: assert property (
    am_sync_port_oe && $past(am_sync_port_oe) |-> am_sync_port_out == rf_gate_on)
    else $error("sync port copy differs from gate");
  atten_low_a: assert property (
    rf_atten_30db |-> !rf_gate_on) else $error("attenuation while gate on");
  atten_edge_a: assert property (
    $rose(rf_atten_30db) && wr_age_q > 4'h8 |-> $fell(rf_gate_on))
    else $error("attenuation not at gate fall");
  half_equal_a: assert property (
    $fell(rf_atten_30db) && rf_gate_on && wr_age_q > 4'h8 ##1 am_sync_port_oe
    |-> $past(lo_cnt_q) == $past(hi_len_q))
    else $error("square halves differ");
  min_width_a: assert property (
    $rose(rf_gate_on) |=> (rf_gate_on || wr_age_q < 4'h8) [*8]) else $error("gate pulse too short");
  low_min_a: assert property (
    $fell(rf_gate_on) && am_sync_port_oe && wr_age_q > 4'h8
    |=> (!rf_gate_on || wr_age_q < 4'h8) [*8])
    else $error("internal gate low too short");
  ext_cause_a: assert property (
    $rose(rf_gate_on) && !am_sync_port_oe && wr_age_q > 4'h8 |-> pin_age_q inside {[4'h2:4'h8]})
    else $error("external pulse without a recent pin edge");
  oe_dir_a: assert property (
    $changed(am_sync_port_oe) |-> wr_age_q < 4'h6) else $error("sync direction changed without write");
  // main scenarios reached
  cov_int_c: cover property ($rose(rf_gate_on) && am_sync_port_oe);
  cov_sq_c: cover property ($rose(rf_atten_30db));
  cov_ext_c: cover property ($rose(rf_gate_on) && !am_sync_port_oe && wr_age_q > 4'h8);
endmodule // amp_pulse_gen_asserts
bind amp_pulse_gen amp_pulse_gen_asserts #(.PRESET_PERIOD_CYC(PRESET_PERIOD_CYC)) chk_u (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .am_sync_port_in(am_sync_port_in), .am_sync_port_out(am_sync_port_out),
  .am_sync_port_oe(am_sync_port_oe), .rf_gate_on(rf_gate_on), .rf_atten_30db(rf_atten_30db));
`default_nettype wire

// ==== test/amp_pulse_gen_test.sv ====
// Purpose: self-checking bench for the modulation gate generator
// Assumes: zero-wait single slave, preset period shortened to 2000 cycles
// Notes:   each measurement skips one period so knob changes settle first
`timescale 1ns/1ns
`default_nettype none
`include "amp_regs.vh"
module amp_pulse_gen_test;
  localparam [19:0] PRE = 20'h0_07d0;
  localparam int    LIMIT = 100000;
  logic        hclk, hresetn, hsel, hwrite, preset, x5, trig;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, rd;
  logic [9:0]  rate;
  logic [6:0]  width;
  wire         hready, sp_out, sp_oe, sp_pin, gate, atten, resp;
  wire  [31:0] hrdata;
  int          err_count, n_tests, hi, lo, n;
  int          cyc = 0;
  amp_pulse_gen #(.PRESET_PERIOD_CYC(PRE)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hresp(resp), .hrdata(hrdata), .pulse_rate_control(preset), .rate_setting(rate),
    .rate_times_five(x5), .width_setting(width), .am_sync_port_in(sp_pin),
    .am_sync_port_out(sp_out), .am_sync_port_oe(sp_oe), .rf_gate_on(gate),
    .rf_atten_30db(atten));
  amp_sync_partner ptn_u (.drv_oe(sp_oe), .drv_val(sp_out), .src_lvl(trig), .pin(sp_pin));
  // free-running 100 MHz clock
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // hang guard
  always @(posedge hclk) begin
    cyc++;
    if (cyc == LIMIT) begin
      err_count++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR at %0t ns seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one single transfer: address phase, then data phase, both held until hready
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask
  task automatic lvl(input logic v);
    do @(posedge hclk); while (gate !== v);
  endtask
  // low then high length of one gate period, ending at the fall
  task automatic meas();
    lvl(1'b1);
    lvl(1'b0);
    lo = 0;
    while (gate !== 1'b1) begin
      lo++;
      @(posedge hclk);
    end
    hi = 0;
    while (gate === 1'b1) begin
      hi++;
      @(posedge hclk);
    end
  endtask
  task automatic meas2();
    meas();
    meas();
  endtask
  // edge latency and pulse length after a trigger, pin toggled mid-pulse
  task automatic ext_pulse(input logic lv);
    trig <= lv;
    n = 0;
    while (gate !== 1'b1 && n < 20) begin
      @(posedge hclk);
      n++;
    end
    hi = 0;
    while (gate === 1'b1) begin
      hi++;
      if (hi == 10) trig <= ~lv;
      if (hi == 20) trig <= lv;
      @(posedge hclk);
    end
  endtask
  task automatic t_idle();
    rdc(`AMP_ADDR_KNOBS, 32'h0614_000c);
    wr(`AMP_ADDR_KNOBS, 32'hffff_ffff);
    chk(resp, 1'b0);
    rdc(`AMP_ADDR_KNOBS, 32'h0614_000c);
    rdc(`AMP_ADDR_STATUS, 32'h0000_0001);
    rdc(32'h0000_0040, 32'h0000_0000);
    wr(`AMP_ADDR_CTRL, 32'h0000_0007);
    rdc(`AMP_ADDR_CTRL, 32'h0000_0000);
    n = 0;
    repeat (3000) begin
      @(posedge hclk);
      if (gate !== 1'b1 || sp_oe !== 1'b0) n++;
    end
    chk(n, 0);
  endtask
  task automatic t_cal();
    preset <= 1'b0;
    x5 <= 1'b0;
    wr(`AMP_ADDR_CTRL, {29'h0, `AMP_MODE_CAL});
    meas2();
    chk(hi, `AMP_CAL_WIDTH_NS / `AMP_CLK_PERIOD_NS);
    chk(hi + lo, PRE);
    rdc(`AMP_ADDR_PERIOD, {12'h000, PRE});
    chk(sp_oe, 1'b1);
  endtask
  task automatic t_var();
    wr(`AMP_ADDR_CTRL, {29'h0, `AMP_MODE_VAR});
    meas2();
    chk(hi, 5 * `AMP_WIDTH_UNIT_NS / `AMP_CLK_PERIOD_NS);
    chk(hi + lo, 12 * `AMP_RATE_UNIT_NS / `AMP_CLK_PERIOD_NS);
    x5 <= 1'b1;
    meas2();
    chk(hi + lo, 12 * `AMP_RATE_UNIT_NS / `AMP_CLK_PERIOD_NS / `AMP_X5_FACTOR);
    preset <= 1'b1;
    width <= 7'h00;
    meas2();
    chk(hi, `AMP_WIDTH_UNIT_NS / `AMP_CLK_PERIOD_NS);
    chk(hi + lo, PRE);
    width <= 7'h7f;
    meas2();
    chk(hi, 100 * `AMP_WIDTH_UNIT_NS / `AMP_CLK_PERIOD_NS);
  endtask
  task automatic t_sq();
    width <= 7'h05;
    preset <= 1'b0;
    wr(`AMP_ADDR_CTRL, {29'h0, `AMP_MODE_SQUARE});
    meas2();
    chk(hi, 1200);
    chk(hi + lo, 2400);
    @(posedge hclk);
    chk(atten, 1'b1);
  endtask
  task automatic t_ext();
    wr(`AMP_ADDR_CTRL, 32'h0000_0104);
    repeat (10) @(posedge hclk);
    chk(sp_oe, 1'b0);
    ext_pulse(1'b1);
    chk(n > 8, 1'b0);
    chk(hi, 50);
    repeat (20) @(posedge hclk);
    chk(gate, 1'b0);
    rdc(`AMP_ADDR_TRIGCNT, 32'h0001_0001);
    wr(`AMP_ADDR_CTRL, 32'h0000_0105);
    repeat (10) @(posedge hclk);
    ext_pulse(1'b0);
    chk(n > 8, 1'b0);
    chk(hi, 50);
    repeat (20) @(posedge hclk);
    rdc(`AMP_ADDR_TRIGCNT, 32'h0001_0001);
  endtask
  // reset, then the scenarios in turn
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0000_0000;
    preset = 1'b1;
    x5 = 1'b1;
    rate = 10'h00c;
    width = 7'h05;
    trig = 1'b0;
    err_count = 0;
    n_tests = 0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk); // knobs need two edges through the synchronisers
    t_idle();
    t_cal();
    t_var();
    t_sq();
    t_ext();
    finish_test();
  end
endmodule // amp_pulse_gen_test
`default_nettype wire

// ==== test/amp_sync_partner.sv ====
// Purpose: far side of the sync coax, a ttl trigger source
// Assumes: bench sets the source level just after a rising hclk edge
// Notes:   sync-receiving gear only listens, so it needs no logic here
`timescale 1ns/1ns
`default_nettype none
module amp_sync_partner (
  // device side of the coax
  input  wire logic drv_oe,
  input  wire logic drv_val,
  // source level commanded by the bench
  input  wire logic src_lvl,
  // resolved coax level
  output wire logic pin
);
  // source backs off while the device drives, so the coax never fights
  assign pin = drv_oe ? drv_val : src_lvl;
endmodule // amp_sync_partner
`default_nettype wire
